// *** dv/port_unit_model.sv ***
// Port unit model: grants timer-output function and predicts toggled pin levels
`timescale 1ns/10ps
module port_unit_model (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic [2:0] i_grant,
  input  wire logic [2:0] i_irq_pulse,
  input  wire logic [2:0] i_pin,
  output logic      [2:0] o_toggle_en,
  output int              o_mismatch,
  output int              o_checks
);
  logic [2:0] level_reg;

  // Grant comes straight from the bench so it can be randomised per test
  assign o_toggle_en = i_grant;

  // Predicted pin flips on each granted timeout; compared before the update lands
  always @(posedge i_clock) begin
    if (i_reset) begin
      level_reg  <= 3'h0;
      o_mismatch <= 0;
      o_checks   <= 0;
    end else begin
      level_reg <= level_reg ^ (i_irq_pulse & i_grant);
      o_checks  <= o_checks + 1;
      if (i_pin !== level_reg) begin
        o_mismatch <= o_mismatch + 1;
        $display("[ERR] %0t pin level %b expected %b", $time, i_pin, level_reg);
      end
    end
  end
endmodule : port_unit_model

// *** dv/test_cascadable_timer_pwm.sv ***
// Self-checking bench for the cascadable timer unit
`timescale 1ns/10ps
module test_cascadable_timer_pwm;
  import timer_pkg::*;
  typedef struct packed { logic [2:0] irq; int lo; int hi; } note_s;
  logic        i_clock = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_osc_stop = 0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        o_pready, o_pslverr, o_interrupt, err_seen;
  logic [2:0]  i_toggle_en, o_timer_out, o_irq_pulse, grant = 3'h0;
  int          n_errors = 0, n_compared = 0, pm_err, pm_chk, n, gap;
  realtime     t_ref = 0;
  note_s       q[$], nt;

  cascadable_timer_pwm u_cascadable_timer_pwm (.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_osc_stop(i_osc_stop), .i_toggle_en(i_toggle_en),
    .o_timer_out(o_timer_out), .o_irq_pulse(o_irq_pulse), .o_interrupt(o_interrupt));
  port_unit_model u_port_unit_model (.i_clock(i_clock), .i_reset(i_reset), .i_grant(grant),
    .i_irq_pulse(o_irq_pulse), .i_pin(o_timer_out), .o_toggle_en(i_toggle_en), .o_mismatch(pm_err),
    .o_checks(pm_chk));

  always #4 i_clock = ~i_clock;

  task automatic err(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : err

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) err($sformatf("got %h expected %h", got, exp));
  endtask : chk

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    err_seen = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic note(input logic [2:0] v, input int lo, input int hi);
    note_s e;
    e.irq = v;
    e.lo  = lo;
    e.hi  = hi;
    q.push_back(e);
  endtask : note

  // Waits for every noted timeout, bounded
  task automatic drain();
    int k;
    for (k = 0; k < 5000 && q.size() != 0; k++) @(posedge i_clock);
    if (q.size() != 0) err("timeout never came");
    q.delete();
    repeat (2) @(posedge i_clock);
  endtask : drain

  // Each pulse takes the oldest note; gap counted in cycles since the reference
  always @(posedge i_clock) begin
    if (!i_reset && o_irq_pulse !== 3'h0) begin
      n_compared++;
      if (q.size() == 0) err($sformatf("unexpected pulse %b", o_irq_pulse));
      else begin
        nt = q.pop_front();
        gap = int'(($time - t_ref) / 8.0);
        if (o_irq_pulse !== nt.irq || gap < nt.lo || gap > nt.hi)
          err($sformatf("pulse %b after %0d expected %b in %0d..%0d", o_irq_pulse, gap, nt.irq, nt.lo, nt.hi));
      end
      t_ref = $time;
    end
  end

  task automatic stop_test();
    n_errors += pm_err;
    n_compared += pm_chk;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    #(8 * 40000);
    n_errors++;
    stop_test();
  end

  initial begin
    n = $urandom(61);
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    grant   <= 3'($urandom);
    // Reset values and an unmapped address
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_STATUS, 32'h0);
    apb(1'b0, 8'h34, 32'h0);
    chk(32'(err_seen), 32'h1);
    // Both independent timers, auto-init: start in step from count 2, then reload 4
    apb(1'b1, OFF_RLO_EVEN, 32'h04);
    apb(1'b1, OFF_RLO_ODD, 32'h04);
    apb(1'b1, OFF_CNT_A_EVEN, 32'h02);
    apb(1'b1, OFF_CNT_A_ODD, 32'h02);
    apb(1'b1, OFF_CTRL, 32'h1B);
    t_ref = $time;
    note(3'h3, 9, 16);
    note(3'h3, 32, 32);
    note(3'h3, 32, 32);
    drain();
    apb(1'b1, OFF_CTRL, 32'h00);
    rchk(OFF_STATUS, 32'h3);
    apb(1'b1, OFF_MASK, 32'h2);
    // Interrupt level follows the register one edge after the write
    @(posedge i_clock);
    chk(32'(o_interrupt), 32'h1);
    apb(1'b1, OFF_STATUS, 32'h2);
    @(posedge i_clock);
    chk(32'(o_interrupt), 32'h0);
    // Single shot on the even timer with a random count
    grant <= 3'($urandom);
    n = int'($urandom_range(1, 8));
    apb(1'b1, OFF_CNT_A_EVEN, 32'(n));
    apb(1'b1, OFF_CTRL, 32'h01);
    t_ref = $time;
    note(3'h1, 8 * (n - 1) + 1, 8 * n);
    drain();
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_CNT_A_EVEN, 32'h0);
    // Cascaded PWM: high value 0x0101, low value 0x0002, counts preset high
    apb(1'b1, OFF_RLO_EVEN, 32'h02);
    apb(1'b1, OFF_RLO_ODD, 32'h00);
    apb(1'b1, OFF_RHI_EVEN, 32'h01);
    apb(1'b1, OFF_RHI_ODD, 32'h01);
    apb(1'b1, OFF_CNT_A_EVEN, 32'h01);
    apb(1'b1, OFF_CNT_A_ODD, 32'h01);
    apb(1'b1, OFF_CTRL, 32'h21);
    t_ref = $time;
    note(3'h2, 2049, 2056);
    note(3'h1, 16, 16);
    note(3'h2, 2056, 2056);
    note(3'h1, 16, 16);
    drain();
    apb(1'b1, OFF_CTRL, 32'h00);
    // Pair B frozen by oscillator stop, then free-running 16-bit; old events cleared first
    apb(1'b1, OFF_STATUS, 32'h3);
    grant <= 3'($urandom) | 3'h4;
    i_osc_stop <= 1'b1;
    apb(1'b1, OFF_RB_EVEN, 32'h05);
    apb(1'b1, OFF_RB_ODD, 32'h00);
    apb(1'b1, OFF_CNT_B_EVEN, 32'h05);
    apb(1'b1, OFF_CNT_B_ODD, 32'h00);
    apb(1'b1, OFF_CTRL, 32'h04);
    repeat (100) @(posedge i_clock);
    rchk(OFF_CNT_B_EVEN, 32'h05);
    @(posedge i_clock);
    i_osc_stop <= 1'b0;
    t_ref = $time;
    note(3'h4, 33, 40);
    note(3'h4, 40, 40);
    drain();
    apb(1'b1, OFF_CTRL, 32'h00);
    rchk(OFF_STATUS, 32'h4);
    stop_test();
  end
endmodule : test_cascadable_timer_pwm

// *** shared/timer_pkg.sv ***
// Register map, field positions and timing constants of the cascadable timer unit
package timer_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // Register byte offsets
  localparam logic [7:0]  OFF_CNT_A_EVEN = 8'h00;
  localparam logic [7:0]  OFF_CNT_A_ODD  = 8'h04;
  localparam logic [7:0]  OFF_CNT_B_EVEN = 8'h08;
  localparam logic [7:0]  OFF_CNT_B_ODD  = 8'h0C;
  localparam logic [7:0]  OFF_RLO_EVEN   = 8'h10;
  localparam logic [7:0]  OFF_RLO_ODD    = 8'h14;
  localparam logic [7:0]  OFF_RHI_EVEN   = 8'h18;
  localparam logic [7:0]  OFF_RHI_ODD    = 8'h1C;
  localparam logic [7:0]  OFF_RB_EVEN    = 8'h20;
  localparam logic [7:0]  OFF_RB_ODD     = 8'h24;
  localparam logic [7:0]  OFF_CTRL       = 8'h28;
  localparam logic [7:0]  OFF_STATUS     = 8'h2C;
  localparam logic [7:0]  OFF_MASK       = 8'h30;
  // Control field positions
  localparam int          CTL_EN_A_EVEN  = 0;
  localparam int          CTL_EN_A_ODD   = 1;
  localparam int          CTL_EN_B       = 2;
  localparam int          CTL_AI_A_EVEN  = 3;
  localparam int          CTL_AI_A_ODD   = 4;
  localparam int          CTL_CASCADE_A  = 5;
  localparam int          CTL_W          = 6;
  // Interrupt channels
  localparam int          IRQ_N          = 3;
  localparam int          IRQ_FIRST      = 0;
  localparam int          IRQ_SECOND     = 1;
  localparam int          IRQ_THIRD      = 2;
  // Reset values
  localparam logic [7:0]  CNT_RST        = 8'h00;
  localparam logic [5:0]  CTL_RST        = 6'h00;
  localparam logic [2:0]  IRQ_RST        = 3'h0;
  // One count every eighth crystal cycle
  localparam int          CRYSTAL_DIV    = 8;
  localparam int          PRESC_W        = $clog2(CRYSTAL_DIV);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CRYSTAL_DIV - 1);
  localparam logic [15:0] CASC_ONE       = 16'h0001;
  localparam logic [7:0]  BYTE_ONE       = 8'h01;
endpackage : timer_pkg

// *** verilog/cascadable_timer_pwm.sv ***
// Four 8-bit down-counters, pair A independent or cascaded PWM, pair B cascaded, APB slave
// Functional notes
// R1: Enabling write starts counting from current count, no reload.
// R2: Enabled timers decrement once every eighth crystal clock cycle.
// R3: Only the internal clock drives counting; no external count input.
// R4: Independent pair A timers are 8-bit, each with its low-phase reload.
// R5: Independent timeout raises its own interrupt; reloads only if auto-init on.
// R6: Cascaded pair A forms the 16-bit PWM-capable timer.
// R7: PWM reloads are odd-over-even low pair and odd-over-even high pair.
// R8: PWM timeouts alternately reload low-phase then high-phase values.
// R9: After enable, low reload first; first timeout raises odd interrupt.
// R10: Low end raises even irq, loads high; high end raises odd, loads low.
// R11: Software preloads both counts with the high-phase value before PWM.
// R12: Enabled timer output pin toggles at each timeout.
// R13: Processor-clock-only stop leaves timers counting and interrupting.
// R14: Oscillator stop halts counting and interrupts.
// R15: Without auto-init the timer stops at zero and clears its enable.
// R16: Cascade: even byte is LSB; one interrupt at 16-bit zero.
// R17: Software count write beats decrement; hardware enable clear beats software.
// R18: 16-bit timers always auto-reload and run freely.
// R19: Interrupt request is a one-cycle pulse in the reload cycle.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module cascadable_timer_pwm (
  input  wire logic                          i_clock,
  input  wire logic                          i_reset,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0]  i_paddr,
  input  wire logic [timer_pkg::DATA_W-1:0]  i_pwdata,
  output logic      [timer_pkg::DATA_W-1:0]  o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  input  wire logic                          i_osc_stop,
  input  wire logic [timer_pkg::IRQ_N-1:0]   i_toggle_en,
  output logic      [timer_pkg::IRQ_N-1:0]   o_timer_out,
  output logic      [timer_pkg::IRQ_N-1:0]   o_irq_pulse,
  output logic                               o_interrupt
);
  import timer_pkg::*;

  logic [7:0]         cnt_reg [4];
  logic [7:0]         rlo_even_reg;
  logic [7:0]         rlo_odd_reg;
  logic [7:0]         rhi_even_reg;
  logic [7:0]         rhi_odd_reg;
  logic [7:0]         rb_even_reg;
  logic [7:0]         rb_odd_reg;
  logic [CTL_W-1:0]   ctrl_reg;
  logic [IRQ_N-1:0]   status_reg;
  logic [IRQ_N-1:0]   mask_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic               pwm_low_reg;
  logic [IRQ_N-1:0]   out_reg;
  logic [DATA_W-1:0]  rdata_reg;

  logic               wr;
  logic               mapped;
  logic               tick;
  logic               casc;
  logic               en_even;
  logic               en_odd;
  logic               en_b;
  logic [15:0]        cnt_a;
  logic [15:0]        cnt_b;
  logic [15:0]        cnt_a_dec;
  logic [15:0]        cnt_b_dec;
  logic               to_even;
  logic               to_odd;
  logic               to_pwm;
  logic               to_b;
  logic [IRQ_N-1:0]   irq;
  logic [3:0]         wr_cnt;
  logic               wr_ctrl;
  logic               start_a;

  // Bus decode; slave never stalls
  assign wr      = i_psel & i_penable & i_pwrite;
  assign wr_ctrl = wr && i_paddr == OFF_CTRL;
  assign wr_cnt  = {wr && i_paddr == OFF_CNT_B_ODD, wr && i_paddr == OFF_CNT_B_EVEN,
                    wr && i_paddr == OFF_CNT_A_ODD, wr && i_paddr == OFF_CNT_A_EVEN};
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_prdata  = rdata_reg;

  // Legal offsets are aligned words up to the mask register
  always_comb begin
    mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= OFF_MASK);
  end

  // Divide-by-eight count enable; oscillator stop freezes everything downstream
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      presc_reg <= '0;
    end else if (!i_osc_stop) begin // R14
      presc_reg <= presc_reg + 1'b1; // R2
    end
  end

  // Processor-clock stop is not seen here, so timers run through it
  assign tick    = (presc_reg == PRESC_LAST) & ~i_osc_stop; // R2 R3 R13 R14
  assign casc    = ctrl_reg[CTL_CASCADE_A];
  assign en_even = ctrl_reg[CTL_EN_A_EVEN];
  assign en_odd  = ctrl_reg[CTL_EN_A_ODD];
  assign en_b    = ctrl_reg[CTL_EN_B];
  // Even byte is the low half of each cascade
  assign cnt_a     = {cnt_reg[1], cnt_reg[0]}; // R16
  assign cnt_b     = {cnt_reg[3], cnt_reg[2]}; // R16
  assign cnt_a_dec = cnt_a - CASC_ONE;
  assign cnt_b_dec = cnt_b - CASC_ONE;

  // Timeouts: the decrement that lands on zero
  assign to_even = tick & ~casc & en_even & (cnt_reg[0] == BYTE_ONE); // R4
  assign to_odd  = tick & ~casc & en_odd & (cnt_reg[1] == BYTE_ONE); // R4
  assign to_pwm  = tick & casc & en_even & (cnt_a == CASC_ONE); // R6
  assign to_b    = tick & en_b & (cnt_b == CASC_ONE); // R16

  // One pulse per timeout, coincident with the reload
  always_comb begin
    irq             = '0;
    irq[IRQ_FIRST]  = to_even | (to_pwm & pwm_low_reg); // R5 R10 R19
    irq[IRQ_SECOND] = to_odd | (to_pwm & ~pwm_low_reg); // R5 R9 R10 R19
    irq[IRQ_THIRD]  = to_b; // R16 R19
  end
  assign o_irq_pulse = irq;

  assign start_a = wr_ctrl & i_pwdata[CTL_EN_A_EVEN] & ~en_even;

  // Control: single-shot clear overrides a same-cycle software write
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_reg <= CTL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= i_pwdata[CTL_W-1:0];
      end
      if (to_even && !ctrl_reg[CTL_AI_A_EVEN]) begin
        ctrl_reg[CTL_EN_A_EVEN] <= 1'b0; // R15 R17
      end
      if (to_odd && !ctrl_reg[CTL_AI_A_ODD]) begin
        ctrl_reg[CTL_EN_A_ODD] <= 1'b0; // R15 R17
      end
    end
  end

  // PWM phase: enabling pretends a high phase is running, so low loads first
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pwm_low_reg <= 1'b0;
    end else if (start_a) begin
      pwm_low_reg <= 1'b0; // R9
    end else if (to_pwm) begin
      pwm_low_reg <= ~pwm_low_reg; // R8
    end
  end

  // Pair A counts; a software write always beats the writeback
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_reg[0] <= CNT_RST;
      cnt_reg[1] <= CNT_RST;
    end else begin
      if (wr_cnt[0]) begin
        cnt_reg[0] <= i_pwdata[7:0]; // R17
      end else if (to_pwm) begin
        cnt_reg[0] <= pwm_low_reg ? rhi_even_reg : rlo_even_reg; // R7 R8 R10 R18
      end else if (casc && tick && en_even) begin
        cnt_reg[0] <= cnt_a_dec[7:0]; // R1 R6
      end else if (to_even && ctrl_reg[CTL_AI_A_EVEN]) begin
        cnt_reg[0] <= rlo_even_reg; // R4 R5
      end else if (!casc && tick && en_even) begin
        cnt_reg[0] <= cnt_reg[0] - BYTE_ONE; // R1 R15
      end
      if (wr_cnt[1]) begin
        cnt_reg[1] <= i_pwdata[7:0]; // R17
      end else if (to_pwm) begin
        cnt_reg[1] <= pwm_low_reg ? rhi_odd_reg : rlo_odd_reg; // R7 R8 R10
      end else if (casc && tick && en_even) begin
        cnt_reg[1] <= cnt_a_dec[15:8]; // R6
      end else if (to_odd && ctrl_reg[CTL_AI_A_ODD]) begin
        cnt_reg[1] <= rlo_odd_reg; // R4 R5
      end else if (!casc && tick && en_odd) begin
        cnt_reg[1] <= cnt_reg[1] - BYTE_ONE; // R1 R15
      end
    end
  end

  // Pair B: always cascaded, always reloading, free running
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_reg[2] <= CNT_RST;
      cnt_reg[3] <= CNT_RST;
    end else begin
      if (wr_cnt[2]) begin
        cnt_reg[2] <= i_pwdata[7:0]; // R17
      end else if (to_b) begin
        cnt_reg[2] <= rb_even_reg; // R18
      end else if (tick && en_b) begin
        cnt_reg[2] <= cnt_b_dec[7:0];
      end
      if (wr_cnt[3]) begin
        cnt_reg[3] <= i_pwdata[7:0]; // R17
      end else if (to_b) begin
        cnt_reg[3] <= rb_odd_reg; // R18
      end else if (tick && en_b) begin
        cnt_reg[3] <= cnt_b_dec[15:8];
      end
    end
  end

  // Reload registers, software only
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rlo_even_reg <= CNT_RST;
      rlo_odd_reg  <= CNT_RST;
      rhi_even_reg <= CNT_RST;
      rhi_odd_reg  <= CNT_RST;
      rb_even_reg  <= CNT_RST;
      rb_odd_reg   <= CNT_RST;
    end else if (wr) begin
      case (i_paddr)
        OFF_RLO_EVEN: rlo_even_reg <= i_pwdata[7:0];
        OFF_RLO_ODD:  rlo_odd_reg  <= i_pwdata[7:0];
        OFF_RHI_EVEN: rhi_even_reg <= i_pwdata[7:0];
        OFF_RHI_ODD:  rhi_odd_reg  <= i_pwdata[7:0];
        OFF_RB_EVEN:  rb_even_reg  <= i_pwdata[7:0];
        OFF_RB_ODD:   rb_odd_reg   <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      status_reg <= IRQ_RST;
      mask_reg   <= IRQ_RST;
    end else begin
      status_reg <= (status_reg & ~((wr && i_paddr == OFF_STATUS) ? i_pwdata[IRQ_N-1:0] : IRQ_RST)) | irq;
      if (wr && i_paddr == OFF_MASK) begin
        mask_reg <= i_pwdata[IRQ_N-1:0];
      end
    end
  end
  assign o_interrupt = |(status_reg & mask_reg);

  // Port toggles only where the port unit grants the timer function
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      out_reg <= IRQ_RST;
    end else begin
      out_reg <= out_reg ^ (irq & i_toggle_en); // R12
    end
  end
  assign o_timer_out = out_reg;

  // Read data captured in the setup phase, ready for the access phase
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_reg <= '0;
    end else if (i_psel && !i_penable) begin
      case (i_paddr)
        OFF_CNT_A_EVEN: rdata_reg <= {24'h000000, cnt_reg[0]};
        OFF_CNT_A_ODD:  rdata_reg <= {24'h000000, cnt_reg[1]};
        OFF_CNT_B_EVEN: rdata_reg <= {24'h000000, cnt_reg[2]};
        OFF_CNT_B_ODD:  rdata_reg <= {24'h000000, cnt_reg[3]};
        OFF_RLO_EVEN:   rdata_reg <= {24'h000000, rlo_even_reg};
        OFF_RLO_ODD:    rdata_reg <= {24'h000000, rlo_odd_reg};
        OFF_RHI_EVEN:   rdata_reg <= {24'h000000, rhi_even_reg};
        OFF_RHI_ODD:    rdata_reg <= {24'h000000, rhi_odd_reg};
        OFF_RB_EVEN:    rdata_reg <= {24'h000000, rb_even_reg};
        OFF_RB_ODD:     rdata_reg <= {24'h000000, rb_odd_reg};
        OFF_CTRL:       rdata_reg <= {26'h0, ctrl_reg};
        OFF_STATUS:     rdata_reg <= {29'h0, status_reg};
        OFF_MASK:       rdata_reg <= {29'h0, mask_reg};
        default:        rdata_reg <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_quiet7;
    !tick [*7];
  endsequence

  property p_tick_rate;
    tick |=> s_quiet7;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("count enable faster than every eighth cycle"); // R2

  property p_irq_pulse;
    |irq |=> irq == '0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse longer than one cycle"); // R19

  property p_osc_stop;
    i_osc_stop |-> irq == '0 && !tick;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("activity while oscillator stopped"); // R14

  property p_sw_wins;
    wr_cnt[0] |=> cnt_reg[0] == $past(i_pwdata[7:0]);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("count write lost"); // R17

  property p_single_shot;
    to_even && !ctrl_reg[CTL_AI_A_EVEN] && !wr_cnt[0] |=> !en_even && cnt_reg[0] == CNT_RST;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single shot did not stop"); // R15

  property p_indep_reload;
    to_even && ctrl_reg[CTL_AI_A_EVEN] && !wr_cnt[0] |=> cnt_reg[0] == $past(rlo_even_reg);
  endproperty
  a_indep_reload: assert property (p_indep_reload) else $error("independent reload wrong"); // R5

  property p_pwm_low_end;
    to_pwm && pwm_low_reg && wr_cnt[1:0] == 2'h0 |=> !pwm_low_reg && cnt_a == {$past(rhi_odd_reg), $past(rhi_even_reg)};
  endproperty
  a_pwm_low_end: assert property (p_pwm_low_end) else $error("low phase end did not load high pair"); // R10

  // High phase end must hand over to the low pair again
  property p_pwm_high_end;
    to_pwm && !pwm_low_reg && wr_cnt[1:0] == 2'h0
      |=> pwm_low_reg && cnt_a == {$past(rlo_odd_reg), $past(rlo_even_reg)};
  endproperty
  a_pwm_high_end: assert property (p_pwm_high_end) else $error("high phase end did not load low pair"); // R8

  // Every pulse must be latched, even against a same-cycle clear
  property p_status_set;
    |irq |=> (status_reg & $past(irq)) == $past(irq);
  endproperty
  a_status_set: assert property (p_status_set) else $error("timeout not latched in status"); // R5

  property p_pwm_first;
    start_a ##1 (!wr_ctrl && casc && en_even) [*1] |-> !pwm_low_reg;
  endproperty
  a_pwm_first: assert property (p_pwm_first) else $error("pwm did not start toward low reload"); // R9

  property p_no_load_on_enable;
    start_a && !wr_cnt[0] && !tick |=> cnt_reg[0] == $past(cnt_reg[0]);
  endproperty
  a_no_load_on_enable: assert property (p_no_load_on_enable) else $error("count loaded on enable"); // R1

  property p_toggle;
    irq[IRQ_THIRD] && i_toggle_en[IRQ_THIRD] |=> o_timer_out[IRQ_THIRD] != $past(o_timer_out[IRQ_THIRD]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("timer output did not toggle"); // R12

endmodule : cascadable_timer_pwm
